/* logic/bce_exec.sv */
// Purpose: executes the overflow branches, compare/decrement branches,
//          transfers, calls, trap, interrupt mask and accumulator pop
// Assumes: mem_rdata_in holds the byte at mem_addr_out in the same cycle
// Notes:   each instruction is padded to its exact cycle count
// Behaviour
// - opcode 30 branches when overflow is clear, 2 cycles or 4 when taken.
// - the overflow-set branch branches when overflow is set, 2 or 4 cycles.
// - FD and 8D branch when A differs from memory, 5/7 and 6/8 cycles, 3 bytes.
// - AC and 7B decrement and branch when nonzero, 5/7 and 4/6 cycles.
// - 1B, 1F and 3F load pc with the target in 3, 5 and 4 cycles.
// - 4F pushes pc high then low and jumps to page FF at the operand, 6 cycles.
// - nA pushes pc high then low and jumps through table entry n, 8 cycles.
// - 0F sets break, pushes pc and status, jumps via FFDE/FFDF, 8 cycles.
// - 60 clears the interrupt enable flag in 3 cycles.
// - E0 sets the interrupt enable flag in 3 cycles.
// - 0D increments sp then loads A from the stack, 4 cycles.
`timescale 1ns/1ns

module bce_exec (
  // clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          rst_in,
  // architectural preload
  input  wire logic          arch_load_in,
  input  wire logic [15:0]   pc_in,
  input  wire logic [7:0]    sp_in,
  input  wire logic [7:0]    acc_in,
  input  wire logic [7:0]    x_in,
  input  wire logic [7:0]    y_in,
  input  wire logic [7:0]    psw_in,
  // memory port
  input  wire logic [7:0]    mem_rdata_in,
  output logic      [15:0]   mem_addr_out,
  output logic               mem_rd_out,
  output logic               mem_wr_out,
  output logic      [7:0]    mem_wdata_out,
  // state view
  output logic      [15:0]   pc_out,
  output logic      [7:0]    sp_out,
  output logic      [7:0]    acc_out,
  output logic      [7:0]    x_out,
  output logic      [7:0]    y_out,
  output logic      [7:0]    psw_out,
  output logic               instr_done_out,
  output logic               unknown_op_out
);
  import bce_pkg::*;

  typedef struct packed {
    bce_state_t  st;
    logic [3:0]  cnt;
    logic [3:0]  total;
    logic [7:0]  op;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  tmp;
    logic [15:0] pc;
    logic [7:0]  sp;
    logic [7:0]  acc;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  processor_status_word;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic        done;
    logic        unk;
  } bce_regs_t;

  bce_regs_t s_reg;
  bce_regs_t s_next;

  // ****************************************
  // decode helpers
  // ****************************************

  // base cycle count of an opcode
  function automatic logic [3:0] base_cycles(input logic [7:0] op);
    logic [3:0] c;
    c = CYC_OTHER;
    case (op)
      OP_BR_OVF_CLEAR, OP_BR_OVF_SET: c = CYC_BR_OVF;
      OP_CALL_ABS, OP_CALL_IND_DP:    c = CYC_CALL;
      OP_CMP_BR_DP:                   c = CYC_CMP_DP;
      OP_CMP_BR_DPX:                  c = CYC_CMP_DPX;
      OP_DEC_BR_DP:                   c = CYC_DEC_DP;
      OP_DEC_BR_Y:                    c = CYC_DEC_Y;
      OP_XFER_ABS:                    c = CYC_XFER_ABS;
      OP_XFER_IND_ABS:                c = CYC_XFER_IABS;
      OP_XFER_IND_DP:                 c = CYC_XFER_IDP;
      OP_UPAGE_CALL:                  c = CYC_UPAGE;
      OP_SW_TRAP:                     c = CYC_SW_TRAP;
      OP_INT_MASK_OFF, OP_INT_MASK_ON: c = CYC_INT_MASK;
      OP_POP_ACC:                     c = CYC_POP;
      default: begin
        if (op[3:0] == OP_TBL_CALL_LO) begin
          c = CYC_TBL_CALL;
        end
      end
    endcase
    return c;
  endfunction

  // direct page address, page chosen by the G flag
  function automatic logic [15:0] dp_addr(input logic g, input logic [7:0] off);
    return {7'h00, g, off};
  endfunction

  // stack location
  function automatic logic [15:0] stk_addr(input logic [7:0] sp);
    return {STACK_PAGE, sp};
  endfunction

  // signed relative target
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
    return pc + {{8{rel[7]}}, rel};
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.rd = 1'b0;
    s_next.wr = 1'b0;
    s_next.done = 1'b0;
    s_next.unk = 1'b0;
    s_next.cnt = s_reg.cnt + 4'h1;
    case (s_reg.st)
      ST_FETCH: begin
        s_next.op = mem_rdata_in;
        s_next.pc = s_reg.pc + 16'h0001;
        s_next.total = base_cycles(mem_rdata_in);
        s_next.st = ST_PAD;
        case (mem_rdata_in)
          OP_INT_MASK_OFF: s_next.processor_status_word[PSW_I_BIT] = 1'b0;
          OP_INT_MASK_ON:  s_next.processor_status_word[PSW_I_BIT] = 1'b1;
          OP_POP_ACC: begin
            s_next.sp = s_reg.sp + 8'h01;
            s_next.addr = stk_addr(s_reg.sp + 8'h01);
            s_next.rd = 1'b1;
            s_next.st = ST_POP;
          end
          OP_SW_TRAP: begin
            s_next.processor_status_word[PSW_B_BIT] = 1'b1;
            s_next.st = ST_PUSHH;
          end
          OP_BR_OVF_CLEAR, OP_BR_OVF_SET, OP_CALL_ABS, OP_CALL_IND_DP,
          OP_CMP_BR_DP, OP_CMP_BR_DPX, OP_DEC_BR_DP, OP_DEC_BR_Y,
          OP_XFER_ABS, OP_XFER_IND_ABS, OP_XFER_IND_DP, OP_UPAGE_CALL: begin
            s_next.addr = s_reg.pc + 16'h0001;
            s_next.rd = 1'b1;
            s_next.st = ST_OP1;
          end
          default: begin
            if (mem_rdata_in[3:0] == OP_TBL_CALL_LO) begin
              s_next.st = ST_PUSHH;
            end else begin
              s_next.unk = 1'b1;
            end
          end
        endcase
        // pushes start with the return address high byte
        if (s_next.st == ST_PUSHH) begin
          s_next.addr = stk_addr(s_reg.sp);
          s_next.wr = 1'b1;
          s_next.wdata = s_next.pc[15:8];
        end
      end
      ST_OP1: begin
        s_next.b1 = mem_rdata_in;
        s_next.pc = s_reg.pc + 16'h0001;
        s_next.st = ST_PAD;
        case (s_reg.op)
          OP_BR_OVF_CLEAR: begin
            if (!s_reg.processor_status_word[PSW_V_BIT]) begin
              s_next.pc = rel_target(s_next.pc, mem_rdata_in);
              s_next.total = s_reg.total + CYC_TAKEN_ADD;
            end
          end
          OP_BR_OVF_SET: begin
            if (s_reg.processor_status_word[PSW_V_BIT]) begin
              s_next.pc = rel_target(s_next.pc, mem_rdata_in);
              s_next.total = s_reg.total + CYC_TAKEN_ADD;
            end
          end
          OP_DEC_BR_Y: begin
            s_next.y = s_reg.y - 8'h01;
            if (s_next.y != 8'h00) begin
              s_next.pc = rel_target(s_next.pc, mem_rdata_in);
              s_next.total = s_reg.total + CYC_TAKEN_ADD;
            end
          end
          OP_XFER_IND_DP, OP_CALL_IND_DP: begin
            s_next.addr = dp_addr(s_reg.processor_status_word[PSW_G_BIT], mem_rdata_in);
            s_next.rd = 1'b1;
            s_next.st = ST_PTRL;
          end
          OP_UPAGE_CALL: begin
            s_next.addr = stk_addr(s_reg.sp);
            s_next.wr = 1'b1;
            s_next.wdata = s_next.pc[15:8];
            s_next.st = ST_PUSHH;
          end
          default: begin
            s_next.addr = s_reg.pc + 16'h0001;
            s_next.rd = 1'b1;
            s_next.st = ST_OP2;
          end
        endcase
      end
      ST_OP2: begin
        s_next.b2 = mem_rdata_in;
        s_next.pc = s_reg.pc + 16'h0001;
        s_next.rd = 1'b1;
        s_next.st = ST_MEM;
        case (s_reg.op)
          OP_CMP_BR_DPX: s_next.addr = dp_addr(s_reg.processor_status_word[PSW_G_BIT], s_reg.b1 + s_reg.x);
          OP_XFER_ABS: begin
            s_next.pc = {mem_rdata_in, s_reg.b1};
            s_next.rd = 1'b0;
            s_next.st = ST_PAD;
          end
          OP_XFER_IND_ABS: begin
            s_next.addr = {mem_rdata_in, s_reg.b1};
            s_next.st = ST_PTRL;
          end
          OP_CALL_ABS: begin
            s_next.addr = stk_addr(s_reg.sp);
            s_next.rd = 1'b0;
            s_next.wr = 1'b1;
            s_next.wdata = s_next.pc[15:8];
            s_next.st = ST_PUSHH;
          end
          default: s_next.addr = dp_addr(s_reg.processor_status_word[PSW_G_BIT], s_reg.b1);
        endcase
      end
      ST_MEM: begin
        s_next.st = ST_PAD;
        if (s_reg.op == OP_DEC_BR_DP) begin
          s_next.tmp = mem_rdata_in - 8'h01;
          s_next.wr = 1'b1;
          s_next.wdata = mem_rdata_in - 8'h01;
          s_next.st = ST_WRB;
        end else if (s_reg.acc != mem_rdata_in) begin
          s_next.pc = rel_target(s_reg.pc, s_reg.b2);
          s_next.total = s_reg.total + CYC_TAKEN_ADD;
        end
      end
      ST_WRB: begin
        s_next.st = ST_PAD;
        if (s_reg.tmp != 8'h00) begin
          s_next.pc = rel_target(s_reg.pc, s_reg.b2);
          s_next.total = s_reg.total + CYC_TAKEN_ADD;
        end
      end
      ST_PTRL: begin
        s_next.tmp = mem_rdata_in;
        s_next.addr = s_reg.addr + 16'h0001;
        s_next.rd = 1'b1;
        s_next.st = ST_PTRH;
      end
      ST_PTRH: begin
        s_next.b2 = mem_rdata_in;
        s_next.st = ST_PAD;
        if (s_reg.op == OP_CALL_IND_DP) begin
          s_next.addr = stk_addr(s_reg.sp);
          s_next.wr = 1'b1;
          s_next.wdata = s_reg.pc[15:8];
          s_next.st = ST_PUSHH;
        end else begin
          s_next.pc = {mem_rdata_in, s_reg.tmp};
        end
      end
      ST_PUSHH: begin
        s_next.sp = s_reg.sp - 8'h01;
        s_next.addr = stk_addr(s_reg.sp - 8'h01);
        s_next.wr = 1'b1;
        s_next.wdata = s_reg.pc[7:0];
        s_next.st = ST_PUSHL;
      end
      ST_PUSHL: begin
        s_next.sp = s_reg.sp - 8'h01;
        s_next.st = ST_PAD;
        case (s_reg.op)
          OP_SW_TRAP: begin
            s_next.addr = stk_addr(s_reg.sp - 8'h01);
            s_next.wr = 1'b1;
            s_next.wdata = s_reg.processor_status_word;
            s_next.st = ST_PUSHP;
          end
          OP_UPAGE_CALL:  s_next.pc = {UPAGE_HIGH, s_reg.b1};
          OP_CALL_ABS:    s_next.pc = {s_reg.b2, s_reg.b1};
          OP_CALL_IND_DP: s_next.pc = {s_reg.b2, s_reg.tmp};
          default: begin
            s_next.addr = TBL_VEC_BASE + {11'h000, s_reg.op[7:4], 1'b0};
            s_next.rd = 1'b1;
            s_next.st = ST_VECL;
          end
        endcase
      end
      ST_PUSHP: begin
        s_next.sp = s_reg.sp - 8'h01;
        s_next.addr = TRAP_VEC_LO;
        s_next.rd = 1'b1;
        s_next.st = ST_VECL;
      end
      ST_VECL: begin
        s_next.tmp = mem_rdata_in;
        s_next.addr = s_reg.addr + 16'h0001;
        s_next.rd = 1'b1;
        s_next.st = ST_VECH;
      end
      ST_VECH: begin
        s_next.pc = {mem_rdata_in, s_reg.tmp};
        s_next.st = ST_PAD;
      end
      ST_POP: begin
        s_next.acc = mem_rdata_in;
        s_next.st = ST_PAD;
      end
      default: s_next.st = ST_PAD;
    endcase
    // padding: the last cycle of the count hands over to the next fetch
    if (s_next.st == ST_PAD && s_reg.cnt == s_next.total - 4'h1) begin
      s_next.st = ST_FETCH;
      s_next.cnt = 4'h0;
      s_next.addr = s_next.pc;
      s_next.rd = 1'b1;
      s_next.done = 1'b1;
    end
    // preload overrides everything and restarts at a fetch
    if (arch_load_in) begin
      s_next.st = ST_FETCH;
      s_next.cnt = 4'h0;
      s_next.pc = pc_in;
      s_next.sp = sp_in;
      s_next.acc = acc_in;
      s_next.x = x_in;
      s_next.y = y_in;
      s_next.processor_status_word = psw_in;
      s_next.addr = pc_in;
      s_next.rd = 1'b1;
      s_next.wr = 1'b0;
      s_next.done = 1'b0;
      s_next.unk = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.st <= ST_FETCH;
      s_reg.pc <= RST_PC;
      s_reg.sp <= RST_SP;
      s_reg.acc <= RST_GPR;
      s_reg.x <= RST_GPR;
      s_reg.y <= RST_GPR;
      s_reg.processor_status_word <= RST_PSW;
      s_reg.addr <= RST_PC;
      s_reg.rd <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign mem_addr_out = s_reg.addr;
  assign mem_rd_out = s_reg.rd;
  assign mem_wr_out = s_reg.wr;
  assign mem_wdata_out = s_reg.wdata;
  assign pc_out = s_reg.pc;
  assign sp_out = s_reg.sp;
  assign acc_out = s_reg.acc;
  assign x_out = s_reg.x;
  assign y_out = s_reg.y;
  assign psw_out = s_reg.processor_status_word;
  assign instr_done_out = s_reg.done;
  assign unknown_op_out = s_reg.unk;

endmodule

/* inc/bce_pkg.sv */
// Purpose: shared constants and types for the branch and control executor
// Assumes: byte-wide asynchronous memory, one access per clock
// Notes:   cycle counts are the non-taken figures; taken branches add two

package bce_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_BR_OVF_CLEAR = 8'h30;
  localparam logic [7:0] OP_BR_OVF_SET   = 8'hB0;
  localparam logic [7:0] OP_CALL_ABS     = 8'h3B;
  localparam logic [7:0] OP_CALL_IND_DP  = 8'h5F;
  localparam logic [7:0] OP_CMP_BR_DP    = 8'hFD;
  localparam logic [7:0] OP_CMP_BR_DPX   = 8'h8D;
  localparam logic [7:0] OP_DEC_BR_DP    = 8'hAC;
  localparam logic [7:0] OP_DEC_BR_Y     = 8'h7B;
  localparam logic [7:0] OP_XFER_ABS     = 8'h1B;
  localparam logic [7:0] OP_XFER_IND_ABS = 8'h1F;
  localparam logic [7:0] OP_XFER_IND_DP  = 8'h3F;
  localparam logic [7:0] OP_UPAGE_CALL   = 8'h4F;
  localparam logic [3:0] OP_TBL_CALL_LO  = 4'hA;
  localparam logic [7:0] OP_SW_TRAP      = 8'h0F;
  localparam logic [7:0] OP_INT_MASK_OFF = 8'h60;
  localparam logic [7:0] OP_INT_MASK_ON  = 8'hE0;
  localparam logic [7:0] OP_POP_ACC      = 8'h0D;

  // ****************************************
  // cycle counts (not taken)
  // ****************************************
  localparam logic [3:0] CYC_BR_OVF    = 4'h2;
  localparam logic [3:0] CYC_CALL      = 4'h8;
  localparam logic [3:0] CYC_CMP_DP    = 4'h5;
  localparam logic [3:0] CYC_CMP_DPX   = 4'h6;
  localparam logic [3:0] CYC_DEC_DP    = 4'h5;
  localparam logic [3:0] CYC_DEC_Y     = 4'h4;
  localparam logic [3:0] CYC_XFER_ABS  = 4'h3;
  localparam logic [3:0] CYC_XFER_IABS = 4'h5;
  localparam logic [3:0] CYC_XFER_IDP  = 4'h4;
  localparam logic [3:0] CYC_UPAGE     = 4'h6;
  localparam logic [3:0] CYC_TBL_CALL  = 4'h8;
  localparam logic [3:0] CYC_SW_TRAP   = 4'h8;
  localparam logic [3:0] CYC_INT_MASK  = 4'h3;
  localparam logic [3:0] CYC_POP       = 4'h4;
  localparam logic [3:0] CYC_OTHER     = 4'h2;
  localparam logic [3:0] CYC_TAKEN_ADD = 4'h2;

  // ****************************************
  // status word bit positions and addresses
  // ****************************************
  localparam int         PSW_V_BIT     = 6;
  localparam int         PSW_G_BIT     = 5;
  localparam int         PSW_B_BIT     = 4;
  localparam int         PSW_I_BIT     = 2;
  localparam logic [7:0] UPAGE_HIGH    = 8'hFF;
  localparam logic [15:0] TRAP_VEC_LO  = 16'hFFDE;
  localparam logic [15:0] TBL_VEC_BASE = 16'hFFC0;
  localparam logic [7:0] STACK_PAGE    = 8'h01;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_PC  = 16'h0000;
  localparam logic [7:0]  RST_SP  = 8'hFF;
  localparam logic [7:0]  RST_PSW = 8'h00;
  localparam logic [7:0]  RST_GPR = 8'h00;

  typedef enum logic [3:0] {
    ST_FETCH, ST_OP1, ST_OP2, ST_MEM, ST_WRB, ST_PTRL, ST_PTRH,
    ST_PUSHH, ST_PUSHL, ST_PUSHP, ST_VECL, ST_VECH, ST_POP, ST_PAD
  } bce_state_t;

endpackage

/* verification/bce_exec_monitor.sv */
// Purpose: port checks for the branch and control executor
// Assumes: each instruction starts at a fetch marked by done or a fresh load
// Notes:   attempts are dropped while a preload is applied
`timescale 1ns/1ns

module bce_exec_monitor (
  // clock, reset and preload
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        arch_load_in,
  // memory port
  input wire logic [7:0]  mem_rdata_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic        mem_rd_out,
  input wire logic        mem_wr_out,
  input wire logic [7:0]  mem_wdata_out,
  // state view
  input wire logic [7:0]  sp_out,
  input wire logic [7:0]  acc_out,
  input wire logic [7:0]  y_out,
  input wire logic [7:0]  psw_out,
  input wire logic        instr_done_out,
  input wire logic        unknown_op_out
);
  // ****************************************
  // fetch marker
  // ****************************************
  logic ld_q;
  logic fetch;

  // reset release or preload restarts at a fetch
  always_ff @(posedge core_clk_in) begin
    ld_q <= rst_in | arch_load_in;
  end
  assign fetch = instr_done_out | ld_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in || arch_load_in);

  // ****************************************
  // properties
  // ****************************************
  property p_ovf_clr;
    fetch && mem_rdata_in == 8'h30 |-> ##2 instr_done_out == $past(psw_out[6], 2);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow-clear branch length wrong");
  property p_ovf_set;
    fetch && mem_rdata_in == 8'hB0 |-> if (psw_out[6]) (##1 !instr_done_out[*3] ##1
      instr_done_out) else (##2 instr_done_out);
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow-set branch length wrong");
  property p_cmp;
    fetch && mem_rdata_in == 8'hFD |=> (!instr_done_out[*4] ##1 instr_done_out) or
      (!instr_done_out[*6] ##1 instr_done_out);
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare branch length wrong");
  property p_dec_y;
    fetch && mem_rdata_in == 8'h7B |-> ##2 (y_out == $past(y_out, 2) - 8'h01) ##2
      (instr_done_out == ($past(y_out, 4) == 8'h01));
  endproperty
  a_dec_y: assert property (p_dec_y)
    else $error("y decrement branch wrong");
  property p_xfer;
    fetch && mem_rdata_in == 8'h1B |=> !instr_done_out[*2] ##1 (instr_done_out &&
      mem_addr_out == {$past(mem_rdata_in), $past(mem_rdata_in, 2)});
  endproperty
  a_xfer: assert property (p_xfer)
    else $error("absolute transfer wrong");
  property p_upage;
    fetch && mem_rdata_in == 8'h4F |-> ##2 (mem_wr_out && mem_addr_out == {8'h01,
      $past(sp_out, 2)}) ##1 (mem_wr_out && mem_addr_out[7:0] == $past(sp_out, 3) - 8'h01)
      ##3 (instr_done_out && mem_addr_out == {8'hFF, $past(mem_rdata_in, 5)});
  endproperty
  a_upage: assert property (p_upage)
    else $error("upper page call wrong");
  property p_tbl;
    fetch && mem_rdata_in[3:0] == 4'hA |=> mem_wr_out[*2] ##1 (mem_rd_out && mem_addr_out ==
      16'hFFC0 + {11'h000, $past(mem_rdata_in[7:4], 3), 1'b0}) ##5 instr_done_out;
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("table call wrong");
  property p_trap;
    fetch && mem_rdata_in == 8'h0F |=> psw_out[4] ##2 (mem_wr_out && mem_wdata_out ==
      psw_out) ##1 (mem_addr_out == 16'hFFDE) ##1 (mem_addr_out == 16'hFFDF) ##3
      instr_done_out;
  endproperty
  a_trap: assert property (p_trap)
    else $error("software trap wrong");
  property p_mask;
    fetch && (mem_rdata_in == 8'h60 || mem_rdata_in == 8'hE0) |=> psw_out[2] ==
      $past(mem_rdata_in[7]) ##0 !instr_done_out[*2] ##1 instr_done_out;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt mask change wrong");
  property p_pop;
    fetch && mem_rdata_in == 8'h0D |=> (mem_rd_out && sp_out == $past(sp_out) + 8'h01 &&
      mem_addr_out == {8'h01, sp_out}) ##1 acc_out == $past(mem_rdata_in) ##2 instr_done_out;
  endproperty
  a_pop: assert property (p_pop)
    else $error("accumulator pop wrong");
  property p_unknown;
    fetch && mem_rdata_in == 8'hFF |=> unknown_op_out ##1 instr_done_out;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unhandled opcode not flagged");

  // main scenarios reached
  c_trap: cover property (fetch && mem_rdata_in == 8'h0F);
  c_tbl: cover property (fetch && mem_rdata_in[3:0] == 4'hA);
  c_cmp: cover property (fetch && mem_rdata_in == 8'hFD);
  c_unknown: cover property (fetch && mem_rdata_in == 8'hFF);
endmodule

/* verification/branch_and_control_execution_tb.sv */
// Purpose: directed tests of the branch and control executor
// Assumes: byte memory held here, answering within the same cycle
// Notes:   each test preloads state, runs one instruction, checks the result
`timescale 1ns/1ns

module branch_and_control_execution_tb;
  // ****************************************
  // signals and memory
  // ****************************************
  logic        core_clk_in  = 1'b0;
  logic        rst_in       = 1'b1;
  logic        arch_load_in = 1'b0;
  logic [15:0] pc_in        = 16'h0000;
  logic [7:0]  sp_in        = 8'hFF;
  logic [7:0]  acc_in       = 8'h00;
  logic [7:0]  x_in         = 8'h00;
  logic [7:0]  y_in         = 8'h00;
  logic [7:0]  psw_in       = 8'h00;
  logic [7:0]  mem_rdata_in;
  logic [15:0] mem_addr_out;
  logic        mem_rd_out;
  logic        mem_wr_out;
  logic [7:0]  mem_wdata_out;
  logic [15:0] pc_out;
  logic [7:0]  sp_out;
  logic [7:0]  acc_out;
  logic [7:0]  y_out;
  logic [7:0]  psw_out;
  logic        instr_done_out;
  logic [7:0]  x_out;
  logic        unknown_op_out;
  logic [7:0]  mem [0:65535];
  int          checks       = 0;
  int          mismatches   = 0;

  bce_exec u_bce_exec (
    .core_clk_in, .rst_in, .arch_load_in, .pc_in, .sp_in, .acc_in, .x_in, .y_in, .psw_in,
    .mem_rdata_in, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out, .pc_out,
    .sp_out, .acc_out, .x_out, .y_out, .psw_out, .instr_done_out, .unknown_op_out
  );

  // clock and same-cycle memory, writes land at the edge
  always #4 core_clk_in = ~core_clk_in;
  assign mem_rdata_in = mem[mem_addr_out];
  always @(posedge core_clk_in) begin
    if (mem_wr_out)
      mem[mem_addr_out] <= mem_wdata_out;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic put(input logic [15:0] adr, input logic [7:0] b0, b1, b2);
    mem[adr] = b0;
    mem[adr + 16'h0001] = b1;
    mem[adr + 16'h0002] = b2;
  endtask

  // preload, run one instruction, check its length and the next fetch address
  task automatic run(input logic [15:0] pc, input logic [7:0] processor_status_word, input int cyc,
                     input logic [15:0] tgt);
    int n;
    logic unk;
    @(negedge core_clk_in);
    pc_in = pc;
    psw_in = processor_status_word;
    arch_load_in = 1'b1;
    @(negedge core_clk_in);
    arch_load_in = 1'b0;
    n = 0;
    unk = 1'b0;
    do begin
      @(negedge core_clk_in);
      n++;
      unk = unk | unknown_op_out;
    end while (instr_done_out !== 1'b1 && n < 40);
    chk(16'(n), 16'(cyc));
    chk(mem_addr_out, tgt);
    chk(pc_out, tgt);
    chk(16'(unk), 16'h0000);
  endtask

  // return address on the stack, high byte first, then wiped
  task automatic pushed(input logic [15:0] ret, input logic [7:0] sp_exp);
    chk(16'(mem[16'h01FF]), 16'(ret[15:8]));
    chk(16'(mem[16'h01FE]), 16'(ret[7:0]));
    chk(16'(sp_out), 16'(sp_exp));
    mem[16'h01FF] = 8'hEE;
    mem[16'h01FE] = 8'hEE;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #(8 * 4000);
    mismatches++;
    results();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'hFF;
    repeat (8) @(negedge core_clk_in);
    rst_in = 1'b0;
    put(16'h0100, 8'h30, 8'h10, 8'hFF);
    run(16'h0100, 8'h40, 2, 16'h0102);
    put(16'h0100, 8'h30, 8'hFE, 8'hFF);
    run(16'h0100, 8'h00, 4, 16'h0100);
    put(16'h0100, 8'hB0, 8'h05, 8'hFF);
    run(16'h0100, 8'h40, 4, 16'h0107);
    run(16'h0100, 8'hBF, 2, 16'h0102);
    $display("test overflow branches done");
    mem[16'h0020] = 8'h55;
    acc_in = 8'h55;
    x_in = 8'h30;
    put(16'h0200, 8'hFD, 8'h20, 8'h10);
    run(16'h0200, 8'h00, 5, 16'h0203);
    put(16'h0200, 8'h8D, 8'hF0, 8'h10);
    run(16'h0200, 8'h00, 6, 16'h0203);
    acc_in = 8'h54;
    run(16'h0200, 8'h00, 8, 16'h0213);
    put(16'h0200, 8'hFD, 8'h20, 8'h10);
    run(16'h0200, 8'h00, 7, 16'h0213);
    chk(16'(x_out), 16'h0030);
    $display("test compare branches done");
    mem[16'h0030] = 8'h01;
    put(16'h0300, 8'hAC, 8'h30, 8'hF0);
    run(16'h0300, 8'h00, 5, 16'h0303);
    chk(16'(mem[16'h0030]), 16'h0000);
    run(16'h0300, 8'h00, 7, 16'h02F3);
    chk(16'(mem[16'h0030]), 16'h00FF);
    put(16'h0300, 8'h7B, 8'h08, 8'hFF);
    y_in = 8'h01;
    run(16'h0300, 8'h00, 4, 16'h0302);
    chk(16'(y_out), 16'h0000);
    y_in = 8'h05;
    run(16'h0300, 8'h00, 6, 16'h030A);
    chk(16'(y_out), 16'h0004);
    $display("test decrement branches done");
    put(16'h0400, 8'h1B, 8'h34, 8'h12);
    run(16'h0400, 8'h00, 3, 16'h1234);
    put(16'h0400, 8'h1F, 8'h00, 8'h05);
    put(16'h0500, 8'h78, 8'h56, 8'hFF);
    run(16'h0400, 8'h00, 5, 16'h5678);
    put(16'h0400, 8'h3F, 8'h40, 8'hFF);
    put(16'h0040, 8'hBC, 8'h9A, 8'hFF);
    run(16'h0400, 8'h00, 4, 16'h9ABC);
    put(16'h0140, 8'h11, 8'h22, 8'hFF);
    run(16'h0400, 8'h20, 4, 16'h2211);
    $display("test transfers done");
    put(16'h0200, 8'h3B, 8'h00, 8'h60);
    run(16'h0200, 8'h00, 8, 16'h6000);
    pushed(16'h0203, 8'hFD);
    put(16'h0200, 8'h5F, 8'h50, 8'hFF);
    put(16'h0050, 8'h00, 8'h70, 8'hFF);
    run(16'h0200, 8'h00, 8, 16'h7000);
    pushed(16'h0202, 8'hFD);
    put(16'h0200, 8'h4F, 8'h34, 8'hFF);
    run(16'h0200, 8'h00, 6, 16'hFF34);
    pushed(16'h0202, 8'hFD);
    for (int n = 0; n < 16; n++) begin
      put(16'h0200, {4'(n), 4'hA}, 8'hFF, 8'hFF);
      put(16'hFFC0 + 16'(2 * n), 8'(n), 8'h80, 8'hFF);
      run(16'h0200, 8'h00, 8, {8'h80, 8'(n)});
      pushed(16'h0201, 8'hFD);
    end
    $display("test calls done");
    put(16'h0200, 8'h0F, 8'hFF, 8'hFF);
    put(16'hFFDE, 8'h00, 8'h90, 8'hFF);
    run(16'h0200, 8'h01, 8, 16'h9000);
    pushed(16'h0201, 8'hFC);
    chk(16'(mem[16'h01FD]), 16'h0011);
    chk(16'(psw_out), 16'h0011);
    put(16'h0200, 8'h60, 8'hFF, 8'hFF);
    run(16'h0200, 8'hFF, 3, 16'h0201);
    chk(16'(psw_out), 16'h00FB);
    put(16'h0200, 8'hE0, 8'hFF, 8'hFF);
    run(16'h0200, 8'h00, 3, 16'h0201);
    chk(16'(psw_out), 16'h0004);
    mem[16'h0181] = 8'h5A;
    sp_in = 8'h80;
    put(16'h0200, 8'h0D, 8'hFF, 8'hFF);
    run(16'h0200, 8'h00, 4, 16'h0201);
    chk(16'(acc_out), 16'h005A);
    chk(16'(sp_out), 16'h0081);
    $display("test trap, mask and pop done");
    results();
  end
endmodule

bind bce_exec bce_exec_monitor u_bce_exec_monitor (
  .core_clk_in, .rst_in, .arch_load_in, .mem_rdata_in, .mem_addr_out, .mem_rd_out,
  .mem_wr_out, .mem_wdata_out, .sp_out, .acc_out, .y_out, .psw_out, .instr_done_out,
  .unknown_op_out
);
